// *** bshb_boot.sv ***
// reset-time strap capture and polled host boot word assembly
// Overview of operation
// - after power-on reset the pll stays bypassed; logic runs on the input clock
// - rom boot loader runs first; core may enable pll only after it finishes
// - boot mode straps captured at power-on reset release pick the boot source
// - code 00 host no pll, 01 i2c, 10 host with pll, 11 reserved
// - host boot uses no dma transfers
// - both sides poll during host boot; no interrupts or requests pace data
// - host port always takes 16-bit words; the captured width strap is only reported
// - captured polarity and mode straps are only reported; host_write is always taken active high
// - port straps captured only at power-on release; hard reset keeps them
// - host data bit 0 is the least significant bit
// - watchdog strap captured at power-on release, ignored afterwards
// - request lines are sampled at reset, then serve as open-drain outputs once a host boot has reached run
// - width strap 0 means 16-bit, 1 means 8-bit
// - polarity strap 0 means active low strobes, 1 active high
`include "bshb_consts.svh"
`default_nettype none
module bshb_boot
#(
    parameter int WORD_BITS = `BSHB_WORD_BITS,
    parameter int GROUP_WORDS = `BSHB_GROUP_WORDS
)
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic hard_reset_n,
    input wire bshb_pkg::bshb_straps_type straps,
    input wire logic boot_done,
    input wire logic pll_enable_request,
    input wire logic host_write,
    input wire logic [15:0] host_data,
    input wire logic group_taken,
    output var bshb_pkg::bshb_config_type boot_config,
    output logic config_valid,
    output logic pll_enable,
    output logic dma_enable,
    output logic irq_pacing_enable,
    output logic host_ready,
    output logic [63:0] boot_group,
    output logic boot_group_valid,
    output logic host_request_oe,
    output logic host_request_out
);
    import bshb_pkg::*;

    bshb_state_all_type s_reg;
    bshb_state_all_type s_next;

    // next-cycle views shared by the output flops and the request pin
    logic run_next;
    logic boot_next;
    logic ready_next;

    // a narrower word count would wrap before the group is complete
    localparam logic [1:0] LAST_WORD = 2'(GROUP_WORDS - 1);

    always_comb
    begin
        s_next = s_reg;
        run_next = 1'b0;
        boot_next = 1'b0;
        ready_next = 1'b0;
        // reset here stands for power-on reset; its release is the capture moment
        if (!s_reg.por_seen)
        begin
            s_next.por_seen = 1'b1;
            s_next.cfg_valid = 1'b1;
            s_next.cfg.host_boot = 1'b0;
            s_next.cfg.i2c_boot = 1'b0;
            s_next.cfg.pll_at_boot = 1'b0;
            s_next.cfg.reserved_mode = 1'b0;
            // the code seen on this one edge picks the boot source until power cycles
            case (straps.boot_mode_straps)
                `BSHB_MODE_HOST_NOPLL:
                begin
                    s_next.cfg.host_boot = 1'b1;
                end
                `BSHB_MODE_I2C:
                begin
                    s_next.cfg.i2c_boot = 1'b1;
                end
                `BSHB_MODE_HOST_PLL:
                begin
                    // only reported: the pll itself still waits for the core
                    s_next.cfg.host_boot = 1'b1;
                    s_next.cfg.pll_at_boot = 1'b1;
                end
                default:
                begin
                    s_next.cfg.reserved_mode = 1'b1;
                end
            endcase
            s_next.cfg.width_8bit = straps.host_width_strap == `BSHB_WIDTH_8;
            s_next.cfg.strobe_active_high =
                straps.host_strobe_polarity_strap == `BSHB_POL_HIGH;
            s_next.cfg.strobe_dual = straps.host_strobe_mode_strap;
            s_next.cfg.watchdog_on = straps.watchdog_enable_strap;
            s_next.cfg.host_boot_mode = {straps.host_request_line,
                straps.host_transmit_request_line};
            s_next.state = BSHB_ST_BOOT;
        end
        else if (!hard_reset_n)
        begin
            // hard reset restarts boot but keeps the strap configuration
            s_next.state = BSHB_ST_BOOT;
            // the pll drops back to bypass with the restart
            s_next.pll_enable = 1'b0;
            // words already taken of a cut group are dropped
            s_next.word_count = 2'h0;
            s_next.group_valid = 1'b0;
        end
        else
        begin
            case (s_reg.state)
                BSHB_ST_BOOT:
                begin
                    if (s_reg.cfg.reserved_mode)
                    begin
                        // no boot source to wait for: park until the next power-on
                        s_next.state = BSHB_ST_HALT;
                    end
                    else if (boot_done)
                    begin
                        s_next.state = BSHB_ST_RUN;
                    end
                    // the consumer frees the group; a write in this cycle is still refused
                    if (s_reg.group_valid && group_taken)
                    begin
                        s_next.group_valid = 1'b0;
                    end
                    // a pending group refuses writes; the host learns it only by polling
                    if (s_reg.cfg.host_boot && host_write && !s_reg.group_valid)
                    begin
                        // first word lands on top; bit 0 of host_data stays lsb
                        s_next.group = {s_reg.group[63 - WORD_BITS:0],
                            host_data[WORD_BITS - 1:0]};
                        // the count wraps to zero on the last word, ready for the next group
                        s_next.word_count = s_reg.word_count + 2'h1;
                        if (s_reg.word_count == LAST_WORD)
                        begin
                            s_next.group_valid = 1'b1;
                        end
                    end
                end
                BSHB_ST_RUN:
                begin
                    // the pll may only raise the speed once the loader is done
                    if (pll_enable_request)
                    begin
                        s_next.pll_enable = 1'b1;
                    end
                    s_next.group_valid = 1'b0;
                end
                BSHB_ST_HALT:
                begin
                    // power-on reset or a hard reset leaves this state
                    s_next.state = BSHB_ST_HALT;
                end
                default:
                begin
                    // an illegal code falls back to boot rather than lock up
                    s_next.state = BSHB_ST_BOOT;
                end
            endcase
        end
        run_next = s_next.state == BSHB_ST_RUN;
        boot_next = s_next.state == BSHB_ST_BOOT;
        // ready is the only pacing the host gets while it boots the device
        ready_next = boot_next && s_next.cfg.host_boot && !s_next.group_valid;
        // request pins keep off the bus until a host boot has reached run
        s_next.host_request_line_oe = s_next.por_seen && s_next.cfg.host_boot && run_next;
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            s_reg <= '0;
            s_reg.state <= BSHB_ST_RESET;
        end
        else
        begin
            // the whole record registers at once; nothing else holds boot state
            s_reg <= s_next;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            boot_config <= '0;
            config_valid <= 1'b0;
            pll_enable <= 1'b0;
            dma_enable <= 1'b0;
            irq_pacing_enable <= 1'b0;
            host_ready <= 1'b0;
            boot_group <= 64'h0;
            boot_group_valid <= 1'b0;
            host_request_oe <= 1'b0;
            host_request_out <= 1'b0;
        end
        else
        begin
            boot_config <= s_next.cfg;
            config_valid <= s_next.cfg_valid;
            pll_enable <= s_next.pll_enable;
            dma_enable <= run_next;
            irq_pacing_enable <= run_next;
            host_ready <= ready_next;
            boot_group <= s_next.group;
            boot_group_valid <= s_next.group_valid;
            host_request_oe <= s_next.host_request_line_oe;
            host_request_out <= 1'b0; // open drain: only ever pulls low
        end
    end
endmodule
`default_nettype wire

// *** bshb_consts.svh ***
// constants for the boot strap and host boot block
`ifndef BSHB_CONSTS_SVH
`define BSHB_CONSTS_SVH
`define BSHB_MODE_HOST_NOPLL 2'h0
`define BSHB_MODE_I2C 2'h1
`define BSHB_MODE_HOST_PLL 2'h2
`define BSHB_MODE_RSVD 2'h3
`define BSHB_WIDTH_16 1'h0
`define BSHB_WIDTH_8 1'h1
`define BSHB_POL_LOW 1'h0
`define BSHB_POL_HIGH 1'h1
`define BSHB_GROUP_WORDS 3'h4
`define BSHB_WORD_BITS 16
`endif

// *** bshb_pkg.sv ***
// types for the boot strap and host boot block
`default_nettype none
package bshb_pkg;
    typedef enum logic [3:0] {
        BSHB_ST_RESET = 4'h1,
        BSHB_ST_BOOT = 4'h2,
        BSHB_ST_RUN = 4'h4,
        BSHB_ST_HALT = 4'h8
    } bshb_state_type;

    typedef struct packed {
        logic [1:0] boot_mode_straps;
        logic host_width_strap;
        logic host_strobe_polarity_strap;
        logic host_strobe_mode_strap;
        logic watchdog_enable_strap;
        logic host_request_line;
        logic host_transmit_request_line;
    } bshb_straps_type;

    typedef struct packed {
        logic host_boot;
        logic i2c_boot;
        logic pll_at_boot;
        logic reserved_mode;
        logic width_8bit;
        logic strobe_active_high;
        logic strobe_dual;
        logic watchdog_on;
        logic [1:0] host_boot_mode;
    } bshb_config_type;

    typedef struct packed {
        bshb_state_type state;
        logic por_seen;
        logic cfg_valid;
        bshb_config_type cfg;
        logic pll_enable;
        logic [1:0] word_count;
        logic [63:0] group;
        logic group_valid;
        logic host_request_line_oe;
    } bshb_state_all_type;
endpackage
`default_nettype wire

// *** bshb_boot_asserts.sv ***
// port assertions for the boot strap block
`default_nettype none
module bshb_boot_asserts
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic hard_reset_n,
    input wire bshb_pkg::bshb_straps_type straps,
    input wire logic boot_done,
    input wire logic pll_enable_request,
    input wire logic [15:0] host_data,
    input wire logic group_taken,
    input wire bshb_pkg::bshb_config_type boot_config,
    input wire logic config_valid,
    input wire logic pll_enable,
    input wire logic dma_enable,
    input wire logic host_ready,
    input wire logic [63:0] boot_group,
    input wire logic boot_group_valid,
    input wire logic host_request_oe,
    input wire logic host_request_out
);
    import bshb_pkg::*;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);
    a_cfg_stable: assert property (config_valid && $past(config_valid) |->
        $stable(boot_config)) else $error("config changed after capture");
    a_mode_decode: assert property ($rose(config_valid) |->
        boot_config.host_boot == !$past(straps.boot_mode_straps[0]) &&
        boot_config.pll_at_boot == ($past(straps.boot_mode_straps) == 2'h2))
        else $error("boot source decode wrong");
    a_port_straps: assert property ($rose(config_valid) |->
        boot_config[5:2] == $past(straps[5:2])) else $error("port straps not captured");
    a_pll_bypass: assert property ($rose(config_valid) |-> !pll_enable)
        else $error("pll on after power-on");
    a_pll_request: assert property ($rose(pll_enable) |-> $past(pll_enable_request))
        else $error("pll on without request");
    a_boot_no_dma: assert property (host_ready |-> !dma_enable && !host_request_oe)
        else $error("dma or request during boot");
    a_group_lsw: assert property ($rose(boot_group_valid) |->
        boot_group[15:0] == $past(host_data)) else $error("last word not in low bits");
    a_group_hold: assert property (boot_group_valid && !group_taken && hard_reset_n &&
        !boot_done && !dma_enable |=> boot_group_valid && !host_ready && $stable(boot_group))
        else $error("pending group lost");
    a_req_drain: assert property (host_request_oe |->
        !host_request_out && boot_config.host_boot && dma_enable && !host_ready)
        else $error("request line driven high");
    c_group: cover property ($rose(boot_group_valid));
    c_pll: cover property ($rose(pll_enable));
    c_i2c: cover property ($rose(config_valid) && boot_config.i2c_boot);
endmodule
bind bshb_boot bshb_boot_asserts u_chk (.sys_clk, .reset, .hard_reset_n, .straps, .boot_done,
    .pll_enable_request, .host_data, .group_taken, .boot_config, .config_valid, .pll_enable,
    .dma_enable, .host_ready, .boot_group, .boot_group_valid, .host_request_oe,
    .host_request_out);
`default_nettype wire

// *** bshb_host_model.sv ***
// host processor model writing boot words into the port
`default_nettype none
module bshb_host_model
(
    input wire logic sys_clk,
    input wire logic host_ready,
    output logic host_write,
    output logic [15:0] host_data
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        host_write = 1'b0;
        host_data = 16'h0000;
    end
    // polled on ready only, most significant word first
    task automatic send(input logic [63:0] value, input logic polled, input int words,
        output logic ok);
        ok = 1'b1;
        for (int i = 0; i < words; i++)
        begin
            for (int n = 0; n < 20 && polled && host_ready !== 1'b1; n++)
                @(posedge sys_clk) #1;
            ok = ok & (host_ready === 1'b1 || !polled);
            host_write = ok;
            host_data = value[63 - 16 * i -: 16];
            @(posedge sys_clk) #1;
        end
        host_write = 1'b0;
        host_data = ~host_data; // released port must not keep the last word
        // one edge passes so a following call never re-raises write in this step
        @(posedge sys_clk) #1;
    endtask
endmodule
`default_nettype wire

// *** testbench.sv ***
// self-checking bench for the boot strap block
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import bshb_pkg::*;
    logic sys_clk = 1'b0, reset = 1'b1, hard_reset_n = 1'b1, boot_done = 1'b0;
    logic pll_enable_request = 1'b0, group_taken = 1'b0, ok, host_write, config_valid;
    logic pll_enable, dma_enable, irq_pacing_enable, host_ready, boot_group_valid;
    logic host_request_oe, host_request_out;
    logic [15:0] host_data;
    logic [63:0] boot_group;
    bshb_straps_type straps = 8'h00;
    bshb_config_type boot_config;
    int bad_count = 0, comparisons = 0;
    logic [7:0] tbl [4] = '{8'h0B, 8'h74, 8'hB5, 8'hEA};
    always #5 sys_clk = ~sys_clk;
    bshb_boot dut (.sys_clk(sys_clk), .reset(reset), .hard_reset_n(hard_reset_n),
        .straps(straps), .boot_done(boot_done), .pll_enable_request(pll_enable_request),
        .host_write(host_write), .host_data(host_data), .group_taken(group_taken),
        .boot_config(boot_config), .config_valid(config_valid), .pll_enable(pll_enable),
        .dma_enable(dma_enable), .irq_pacing_enable(irq_pacing_enable),
        .host_ready(host_ready), .boot_group(boot_group), .boot_group_valid(boot_group_valid),
        .host_request_oe(host_request_oe), .host_request_out(host_request_out));
    bshb_host_model host (.sys_clk(sys_clk), .host_ready(host_ready),
        .host_write(host_write), .host_data(host_data));
    task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
        comparisons++;
        if (got !== exp)
        begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    function automatic bshb_config_type cfg_of(input logic [7:0] s);
        return {!s[6], s[7:6] == 2'h1, s[7:6] == 2'h2, s[7:6] == 2'h3, s[5:0]};
    endfunction
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic tally_and_finish;
        $display("mismatches %0d comparisons %0d", bad_count, comparisons);
        if (bad_count == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // straps stay steady through reset, then flip to their inverse
    task automatic power_up(input logic [7:0] s);
        reset = 1'b1;
        straps = s;
        step(10);
        reset = 1'b0;
        step(2);
        check("cfg", cfg_of(s), boot_config);
        check("cfg valid", 1'h1, config_valid);
        straps = ~s;
        step(3);
        check("cfg held", cfg_of(s), boot_config);
    endtask
    initial
    begin
        for (int m = 0; m < 4; m++)
        begin
            power_up(tbl[m]);
            host.send(64'h8421_0F0F_C3A5_1234 + m, 1'b1, 4, ok);
            check("accepted", m[0] == 1'h0, ok);
            check("group", m[0] ? 64'h0 : 64'h8421_0F0F_C3A5_1234 + m, boot_group);
        end
        host.send(64'h5555_6666_7777_8888, 1'b0, 4, ok);
        check("reserved", 1'h0, boot_group_valid);
        power_up(tbl[0]);
        host.send(64'hFFFF_EEEE_0000_0000, 1'b1, 2, ok);
        hard_reset_n = 1'b0;
        step(2);
        hard_reset_n = 1'b1;
        step(2);
        check("cfg hard", cfg_of(tbl[0]), boot_config);
        host.send(64'h0001_0203_0405_0607, 1'b1, 4, ok);
        check("group", 64'h0001_0203_0405_0607, boot_group);
        host.send(64'h1111_2222_3333_4444, 1'b0, 4, ok);
        check("pending", 64'h0001_0203_0405_0607, boot_group);
        group_taken = 1'b1;
        step(1);
        group_taken = 1'b0;
        step(1);
        check("ready", 2'h1, {boot_group_valid, host_ready});
        pll_enable_request = 1'b1;
        step(3);
        check("pll early", 1'h0, pll_enable);
        boot_done = 1'b1;
        step(1);
        boot_done = 1'b0;
        step(3);
        check("run", 5'h1E, {pll_enable, dma_enable, irq_pacing_enable, host_request_oe,
            host_request_out});
        tally_and_finish;
    end
    initial
    begin
        #300000;
        bad_count++;
        tally_and_finish;
    end
endmodule
`default_nettype wire
